// >>> mscg_pkg.sv
// Constants shared by both ends of the module standby clock gate
// Functional notes
// - Set stop bit halts module next bus cycle
// - Reads of stopped module return FF
// - Writes to stopped module are discarded
// - Standby entry restores module registers, flags
// - Stopped module pins revert to GPIO
// - Stop DMA/refresh only without bus request
// - Disable module interrupt before stopping it; host masks it in the same cycle
// - Clear stop bit, then reprogram module
// - Keep former serial receive pin input
// - Control register written by CPU only
// - Clock stop bit set floats clock pin
// - Clock stop bit clear drives clock
// - Clock pin state per operating mode
package mscg_pkg;

  // ************************************************************
  // Address map
  // ************************************************************
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [3:0] MOD_WIN_FIRST = 4'h1;
  localparam logic [7:0] HOST_STAT_OFS = 8'hF0;
  localparam logic [7:0] HOST_IRQ_OFS  = 8'hF1;
  localparam logic [7:0] HOST_DIR_OFS  = 8'hF2;

  // ************************************************************
  // Control register layout
  // ************************************************************
  localparam int         MOD_NUM       = 6;
  localparam int         MOD_REG_CNT   = 4;
  localparam int         STOP_LSB      = 0;
  localparam int         MOD_ADC       = 0;
  localparam int         MOD_REFRESH   = 1;
  localparam int         MOD_DMA       = 2;
  localparam int         MOD_SER1      = 3;
  localparam int         MOD_SER0      = 4;
  localparam int         MOD_TIMER     = 5;
  localparam int         CLK_STOP_BIT  = 7;
  localparam logic [7:0] CTRL_RST      = 8'h00;
  localparam logic [7:0] CTRL_WMASK    = 8'hBF;

  // ************************************************************
  // Module register values
  // ************************************************************
  localparam logic [7:0] MOD_REG_INIT  = 8'h00;
  localparam logic [7:0] STOPPED_READ  = 8'hFF;
  localparam int         FLAG_BIT      = 0;
  localparam int         REFUSED_BIT   = 7;

endpackage

// >>> mscg_bus_if.sv
// Bus between the control/supporting-module end and the CPU bus end
`timescale 1ns/1ps
`default_nettype none
interface mscg_bus_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic       dma;
  logic [7:0] rdata;
  logic [1:0] busreq;

  modport dev  (input addr, wdata, wr, rd, dma, output rdata, busreq);
  modport host (output addr, wdata, wr, rd, dma, input rdata, busreq);
endinterface
`default_nettype wire

// >>> mscg_dev.sv
// Control register, module standby gating and clock output pin
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mscg_dev (
  // Clock, reset and enable
  input  wire logic                        core_clk_i,
  input  wire logic                        arst_n_i,
  input  wire logic                        ce_i,
  // CPU bus
  mscg_bus_if.dev                          bus,
  // Supporting module events
  input  wire logic [mscg_pkg::MOD_NUM-1:0] mod_event_i,
  input  wire logic                        dma_busreq_i,
  input  wire logic                        refresh_busreq_i,
  // Operating state
  input  wire logic                        hw_standby_i,
  input  wire logic                        sw_standby_i,
  // Module gating
  output logic [mscg_pkg::MOD_NUM-1:0]     mod_clk_en_o,
  output logic [mscg_pkg::MOD_NUM-1:0]     mod_rst_o,
  output logic [mscg_pkg::MOD_NUM-1:0]     pin_func_en_o,
  output logic [mscg_pkg::MOD_NUM*mscg_pkg::MOD_REG_CNT*8-1:0] mod_reg_o,
  output logic [7:0]                       ctrl_o,
  // System clock output pin
  output logic                             clkout_o,
  output logic                             clkout_oe_o
);
  import mscg_pkg::*;

  // ************************************************************
  // Decode
  // ************************************************************
  logic [7:0]         ctrl_q;
  logic [MOD_NUM-1:0] stop;
  logic [3:0]         win;
  logic [3:0]         sel;
  logic [1:0]         ridx;
  logic               ctrl_hit;
  logic               mod_hit;
  logic               cpu_wr;
  logic [7:0]         rd_d;
  logic [7:0]         rdata_q;
  logic [7:0]         regs_q [MOD_NUM][MOD_REG_CNT];

  assign stop     = ctrl_q[STOP_LSB +: MOD_NUM];
  assign win      = bus.addr[7:4];
  assign sel      = win - MOD_WIN_FIRST;
  assign ridx     = bus.addr[1:0];
  assign ctrl_hit = (bus.addr == CTRL_OFS);
  assign mod_hit  = (win >= MOD_WIN_FIRST) && ({28'h0, sel} < MOD_NUM)
                    && (bus.addr[3:2] == 2'h0);
  assign cpu_wr   = bus.wr && !bus.dma;

  // ************************************************************
  // Control register
  // ************************************************************
  // DMA writes are dropped; DMA reads are answered normally
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= CTRL_RST;
    end else if (ce_i) begin
      if (cpu_wr && ctrl_hit) begin
        ctrl_q <= bus.wdata & CTRL_WMASK;
      end
    end
  end

  assign ctrl_o = ctrl_q;

  // ************************************************************
  // Standby entry
  // ************************************************************
  // A stop bit being written clears its module on that same edge, so the
  // next bus cycle already finds the module at its initial values
  logic [MOD_NUM-1:0] stop_wr;
  logic [MOD_NUM-1:0] halt;

  assign stop_wr = (cpu_wr && ctrl_hit) ? bus.wdata[STOP_LSB +: MOD_NUM] : '0;
  assign halt    = stop | stop_wr;

  // ************************************************************
  // Supporting module registers
  // ************************************************************
  genvar m;
  generate
    for (m = 0; m < MOD_NUM; m++) begin : g_mod
      always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          for (int r = 0; r < MOD_REG_CNT; r++) begin
            regs_q[m][r] <= MOD_REG_INIT;
          end
        end else if (ce_i) begin
          for (int r = 0; r < MOD_REG_CNT; r++) begin
            if (halt[m]) begin
              regs_q[m][r] <= MOD_REG_INIT;
            end else begin
              if (bus.wr && mod_hit && (sel == 4'(m)) && (ridx == 2'(r))) begin
                regs_q[m][r] <= bus.wdata;
              end
              // Event flag: a set in the clearing cycle wins
              if ((r == 0) && mod_event_i[m]) begin
                regs_q[m][r][FLAG_BIT] <= 1'b1;
              end
            end
          end
        end
      end

      for (genvar r = 0; r < MOD_REG_CNT; r++) begin : g_reg
        assign mod_reg_o[(m*MOD_REG_CNT+r)*8 +: 8] = regs_q[m][r];
      end
    end
  endgenerate

  // ************************************************************
  // Gating outputs
  // ************************************************************
  assign mod_clk_en_o  = ~stop;
  assign mod_rst_o     = stop;
  assign pin_func_en_o = ~stop;

  // ************************************************************
  // Read path
  // ************************************************************
  always_comb begin
    rd_d = 8'h00;
    if (ctrl_hit) begin
      rd_d = ctrl_q;
    end else if (mod_hit) begin
      if (stop[sel[2:0]]) begin
        rd_d = STOPPED_READ;
      end else begin
        rd_d = regs_q[sel[2:0]][ridx];
      end
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      rdata_q <= bus.rd ? rd_d : 8'h00;
    end
  end

  assign bus.rdata  = rdata_q;
  assign bus.busreq = {dma_busreq_i, refresh_busreq_i};

  // ************************************************************
  // System clock output pin
  // ************************************************************
  // The pin shows the core clock divided by two
  typedef enum logic [1:0] {
    PIN_FLOAT,
    PIN_HIGH,
    PIN_TOGGLE
  } mscg_pin_mode_t;

  mscg_pin_mode_t pin_mode;
  logic           clk_div_q;
  logic           clkout_q;
  logic           clkout_oe_q;

  // The stop bit floats the pin in every operating state
  always_comb begin
    pin_mode = PIN_TOGGLE;
    if (ctrl_q[CLK_STOP_BIT] || hw_standby_i) begin
      pin_mode = PIN_FLOAT;
    end else if (sw_standby_i) begin
      pin_mode = PIN_HIGH;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_div_q <= 1'b0;
    end else if (ce_i) begin
      clk_div_q <= ~clk_div_q;
    end
  end

  // Output enable is high while the pin is driven
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clkout_oe_q <= 1'b0;
    end else if (ce_i) begin
      case (pin_mode)
        PIN_FLOAT: clkout_oe_q <= 1'b0;
        default:   clkout_oe_q <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clkout_q <= 1'b0;
    end else if (ce_i) begin
      case (pin_mode)
        PIN_HIGH:   clkout_q <= 1'b1;
        PIN_TOGGLE: clkout_q <= ~clk_div_q;
        default:    clkout_q <= 1'b0;
      endcase
    end
  end

  assign clkout_o    = clkout_q;
  assign clkout_oe_o = clkout_oe_q;

endmodule
`default_nettype wire

// >>> mscg_host.sv
// CPU bus end: issues bus cycles and keeps the software obligations
`timescale 1ns/1ps
`default_nettype none
module mscg_host (
  // Clock, reset and enable
  input  wire logic                        core_clk_i,
  input  wire logic                        arst_n_i,
  input  wire logic                        ce_i,
  // Software port
  input  wire logic [7:0]                  sw_addr_i,
  input  wire logic [7:0]                  sw_wdata_i,
  input  wire logic                        sw_wr_i,
  input  wire logic                        sw_rd_i,
  input  wire logic                        sw_dma_i,
  output logic [7:0]                       sw_rdata_o,
  // Side controls
  output logic [mscg_pkg::MOD_NUM-1:0]     irq_en_o,
  output logic [1:0]                       rx_dir_o,
  // Bus to the device end
  mscg_bus_if.host                         bus
);
  import mscg_pkg::*;

  // ************************************************************
  // Decode and refusal
  // ************************************************************
  logic [7:0]         shadow_q;
  logic [MOD_NUM-1:0] need_setup_q;
  logic [MOD_NUM-1:0] irq_en_q;
  logic [1:0]         dir_q;
  logic               refused_q;
  logic               host_rd_q;
  logic [7:0]         host_rdata_q;
  logic               host_hit;
  logic               ctrl_wr;
  logic               refuse;
  logic [MOD_NUM-1:0] new_stop;
  logic [MOD_NUM-1:0] rise;
  logic [MOD_NUM-1:0] fall;
  logic [3:0]         sel;

  assign host_hit = (sw_addr_i[7:4] == HOST_STAT_OFS[7:4]);
  assign ctrl_wr  = sw_wr_i && !sw_dma_i && (sw_addr_i == CTRL_OFS);
  assign new_stop = sw_wdata_i[STOP_LSB +: MOD_NUM];
  assign rise     = new_stop & ~shadow_q[STOP_LSB +: MOD_NUM];
  assign fall     = ~new_stop & shadow_q[STOP_LSB +: MOD_NUM];
  assign sel      = sw_addr_i[7:4] - MOD_WIN_FIRST;
  assign refuse   = ctrl_wr && ((rise[MOD_DMA] && bus.busreq[1])
                    || (rise[MOD_REFRESH] && bus.busreq[0]));

  assign bus.addr  = sw_addr_i;
  assign bus.wdata = sw_wdata_i;
  assign bus.wr    = sw_wr_i && !host_hit && !refuse;
  assign bus.rd    = sw_rd_i && !host_hit;
  assign bus.dma   = sw_dma_i;

  // ************************************************************
  // Control shadow and follow-up state
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shadow_q <= CTRL_RST;
    end else if (ce_i && ctrl_wr && !refuse) begin
      shadow_q <= sw_wdata_i & CTRL_WMASK;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      refused_q <= 1'b0;
    end else if (ce_i) begin
      if (refuse) begin
        refused_q <= 1'b1;
      end else if (sw_wr_i && (sw_addr_i == HOST_STAT_OFS)
                   && sw_wdata_i[REFUSED_BIT]) begin
        refused_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      need_setup_q <= '0;
    end else if (ce_i) begin
      for (int m = 0; m < MOD_NUM; m++) begin
        if (ctrl_wr && !refuse && fall[m]) begin
          need_setup_q[m] <= 1'b1;
        end else if (sw_wr_i && (sel == 4'(m))) begin
          need_setup_q[m] <= 1'b0;
        end
      end
    end
  end

  // Interrupts of modules being stopped are masked in the same cycle
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_en_q <= '0;
    end else if (ce_i) begin
      if (ctrl_wr && !refuse) begin
        irq_en_q <= irq_en_q & ~new_stop;
      end else if (sw_wr_i && (sw_addr_i == HOST_IRQ_OFS)) begin
        irq_en_q <= sw_wdata_i[MOD_NUM-1:0] & ~shadow_q[STOP_LSB +: MOD_NUM];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dir_q <= 2'h0;
    end else if (ce_i) begin
      if (sw_wr_i && (sw_addr_i == HOST_DIR_OFS)) begin
        dir_q <= sw_wdata_i[1:0];
      end else begin
        dir_q <= dir_q & ~{shadow_q[MOD_SER1], shadow_q[MOD_SER0]};
      end
    end
  end

  assign irq_en_o = irq_en_q;
  assign rx_dir_o = dir_q & ~{shadow_q[MOD_SER1], shadow_q[MOD_SER0]};

  // ************************************************************
  // Read return
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_rd_q    <= 1'b0;
      host_rdata_q <= 8'h00;
    end else if (ce_i) begin
      host_rd_q    <= sw_rd_i && host_hit;
      host_rdata_q <= 8'h00;
      if (sw_rd_i && (sw_addr_i == HOST_STAT_OFS)) begin
        host_rdata_q <= {refused_q, 1'b0, need_setup_q};
      end else if (sw_rd_i && (sw_addr_i == HOST_IRQ_OFS)) begin
        host_rdata_q <= {2'h0, irq_en_q};
      end else if (sw_rd_i && (sw_addr_i == HOST_DIR_OFS)) begin
        host_rdata_q <= {6'h00, rx_dir_o};
      end
    end
  end

  assign sw_rdata_o = host_rd_q ? host_rdata_q : bus.rdata;

endmodule
`default_nettype wire

// >>> mscg_props.sv
// Bus checker for the module standby clock gate
`timescale 1ns/1ps
`default_nettype none
module mscg_props
  import mscg_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk_i,
  input wire logic       arst_n_i,
  // Bus signals
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic       dma,
  input wire logic [7:0] rdata,
  input wire logic [1:0] busreq
);
  // ****
  // Shadow of control and module state
  // ****
  logic [7:0] ctl_q;
  logic [5:0] fresh_q;
  logic [3:0] m;
  logic       win;
  logic       stp;
  logic       refuse;
  assign m      = addr[7:4] - 4'h1;
  assign win    = addr[7:4] >= 4'h1 && addr[7:4] <= 4'h6 && addr[3:2] == 2'h0;
  assign stp    = ctl_q[m[2:0]];
  assign refuse = (wdata[MOD_DMA] & ~ctl_q[MOD_DMA] & busreq[1])
                | (wdata[MOD_REFRESH] & ~ctl_q[MOD_REFRESH] & busreq[0]);
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) ctl_q <= CTRL_RST;
    else if (wr && !dma && addr == CTRL_OFS && !refuse) ctl_q <= wdata & CTRL_WMASK;
  end
  // Module registers known to hold initial values
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) fresh_q <= 6'h3F;
    else fresh_q <= (fresh_q | ctl_q[5:0]) & ~((wr && win && !stp) ? 6'h01 << m : 6'h00);
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_keep;
    !wr ##1 rd && addr == CTRL_OFS;
  endsequence
  property p_ctrl_read;
    rd && addr == CTRL_OFS |=> rdata == ctl_q;
  endproperty
  property p_stop_read;
    rd && win && stp |=> rdata == STOPPED_READ;
  endproperty
  property p_reinit;
    rd && win && !stp && fresh_q[m[2:0]] && addr[1:0] != 2'h0 |=> rdata == MOD_REG_INIT;
  endproperty
  property p_refused;
    wr && !dma && addr == CTRL_OFS |-> !refuse;
  endproperty
  property p_dma_wr;
    wr && dma && addr == CTRL_OFS ##1 s_keep |=> rdata == $past(ctl_q, 3);
  endproperty
  property p_live_wr;
    wr && win && !stp && addr[1:0] != 2'h0 ##1 !wr ##1 rd && addr == $past(addr, 2)
      |=> rdata == $past(wdata, 3);
  endproperty
  property p_quiet;
    !rd |=> rdata == 8'h00;
  endproperty
  property p_unmapped;
    rd && addr[7:4] == 4'h0 && addr != CTRL_OFS |=> rdata == 8'h00;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl readback");
  a_stop_read: assert property (p_stop_read) else $error("stopped read");
  a_reinit: assert property (p_reinit) else $error("not reinitialised");
  a_refused: assert property (p_refused) else $error("refused write applied");
  a_dma_wr: assert property (p_dma_wr) else $error("dma write applied");
  a_live_wr: assert property (p_live_wr) else $error("live write lost");
  a_quiet: assert property (p_quiet) else $error("read data outside read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for both ends of the module standby clock gate
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mscg_pkg::*;
  // ****
  // Signals and ends
  // ****
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         hw = 1'b0;
  logic         sw = 1'b0;
  logic         dreq = 1'b0;
  logic         rreq = 1'b0;
  logic [7:0]   a = 8'h00;
  logic [7:0]   d = 8'h00;
  logic         wr = 1'b0;
  logic         rd = 1'b0;
  logic         dm = 1'b0;
  logic [5:0]   ev = 6'h00;
  logic [7:0]   rdat;
  logic [7:0]   ctl;
  logic [7:0]   v;
  logic [5:0]   cen;
  logic [5:0]   mrst;
  logic [5:0]   pfe;
  logic [5:0]   irq;
  logic [1:0]   dir;
  logic [191:0] mreg;
  logic         ck;
  logic         ckoe;
  int           err_count = 0;
  int           n_tests = 0;
  int           seed = 97;
  always #20 clk = ~clk;
  mscg_bus_if i_mscg_bus_if ();
  mscg_dev i_mscg_dev (.core_clk_i(clk), .arst_n_i(rst_n), .ce_i(1'b1), .bus(i_mscg_bus_if),
    .mod_event_i(ev), .dma_busreq_i(dreq), .refresh_busreq_i(rreq), .hw_standby_i(hw),
    .sw_standby_i(sw), .mod_clk_en_o(cen), .mod_rst_o(mrst), .pin_func_en_o(pfe),
    .mod_reg_o(mreg), .ctrl_o(ctl), .clkout_o(ck), .clkout_oe_o(ckoe));
  mscg_host i_mscg_host (.core_clk_i(clk), .arst_n_i(rst_n), .ce_i(1'b1), .sw_addr_i(a),
    .sw_wdata_i(d), .sw_wr_i(wr), .sw_rd_i(rd), .sw_dma_i(dm), .sw_rdata_o(rdat),
    .irq_en_o(irq), .rx_dir_o(dir), .bus(i_mscg_bus_if));
  mscg_props i_mscg_props (.core_clk_i(clk), .arst_n_i(rst_n), .addr(i_mscg_bus_if.addr),
    .wdata(i_mscg_bus_if.wdata), .wr(i_mscg_bus_if.wr), .rd(i_mscg_bus_if.rd),
    .dma(i_mscg_bus_if.dma), .rdata(i_mscg_bus_if.rdata), .busreq(i_mscg_bus_if.busreq));
  // ****
  // Tasks and expectations
  // ****
  function automatic logic [7:0] oh(input int m);
    return 8'h01 << m;
  endfunction
  function automatic logic [7:0] ma(input int m, input int r);
    return 8'((m + 1) * 16 + r);
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic bw(input logic [7:0] ad, input logic [7:0] dt, input logic m);
    @(posedge clk);
    {a, d, wr, dm} <= {ad, dt, 1'b1, m};
    @(posedge clk);
    {wr, dm} <= 2'h0;
    #1;
  endtask
  task automatic br(input logic [7:0] ad, input logic [7:0] e, input logic m);
    @(posedge clk);
    {a, rd, dm} <= {ad, 1'b1, m};
    @(posedge clk);
    {rd, dm} <= 2'h0;
    #1;
    chk(rdat, e);
  endtask
  task automatic give_verdict;
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    br(CTRL_OFS, CTRL_RST, 1'b0);
    chk(8'(ckoe), 8'h01);
    for (int m = 0; m < MOD_NUM; m++) begin
      v = 8'($random(seed));
      bw(HOST_DIR_OFS, 8'h03, 1'b0);
      bw(HOST_IRQ_OFS, 8'h3F, 1'b0);
      bw(ma(m, 1), v, 1'b0);
      br(ma(m, 1), v, 1'b0);
      ev <= 6'(oh(m));
      @(posedge clk);
      ev <= 6'h00;
      br(ma(m, 0), 8'h01, 1'b0);
      bw(CTRL_OFS, oh(m), 1'b0);
      chk(ctl, oh(m));
      chk({2'h0, cen}, ~oh(m) & 8'h3F);
      chk({2'h0, mrst}, oh(m));
      chk({2'h0, pfe}, ~oh(m) & 8'h3F);
      chk({2'h0, irq}, ~oh(m) & 8'h3F);
      chk(8'(dir), 8'({m != MOD_SER1, m != MOD_SER0}));
      chk(mreg[(m * 4 + 1) * 8 +: 8], MOD_REG_INIT);
      chk(mreg[m * 32 +: 8], MOD_REG_INIT);
      bw(ma(m, 1), ~v, 1'b0);
      br(ma(m, 1), STOPPED_READ, 1'b0);
      br(ma(m, 0), STOPPED_READ, 1'b0);
      bw(CTRL_OFS, 8'h00, 1'b0);
      br(ma(m, 1), MOD_REG_INIT, 1'b0);
    end
    dreq <= 1'b1;
    bw(CTRL_OFS, oh(MOD_DMA), 1'b0);
    br(CTRL_OFS, 8'h00, 1'b0);
    br(HOST_STAT_OFS, 8'hBF, 1'b0);
    {dreq, rreq} <= 2'h1;
    bw(CTRL_OFS, oh(MOD_REFRESH), 1'b0);
    br(CTRL_OFS, 8'h00, 1'b0);
    rreq <= 1'b0;
    v = 8'($random(seed));
    bw(CTRL_OFS, v, 1'b0);
    bw(CTRL_OFS, ~v, 1'b1);
    br(CTRL_OFS, v & CTRL_WMASK, 1'b1);
    br(8'h05, 8'h00, 1'b0);
    for (int i = 0; i < 8; i++) begin
      bw(CTRL_OFS, {i[2], 7'h00}, 1'b0);
      {hw, sw} <= i[1:0];
      repeat (2) @(posedge clk);
      #1;
      chk(8'(ckoe), {7'h00, ~(i[2] | i[1])});
      if (i[2:0] == 3'h1) chk(8'(ck), 8'h01);
    end
    {hw, sw} <= 2'h0;
    bw(CTRL_OFS, 8'h00, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    v[0] = ck;
    @(posedge clk);
    #1;
    chk(8'(ck), {7'h00, ~v[0]});
    give_verdict();
  end
endmodule
`default_nettype wire
